// *** logic/alu_ops_pkg.sv ***
// package for the 8-bit arithmetic/logic unit: operation codes and flag layout
// assumes a single core clock and an external register file / status register
package alu_ops_pkg;
    localparam int DATA_W = 8;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] ALL_ZERO = 8'h00;
    localparam logic [7:0] ONE_VAL = 8'h01;
    localparam logic [7:0] MSB_MASK = 8'h80;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_H = 4;
    localparam int FLAG_W = 5;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    typedef enum logic [3:0] {
        OP_NONE,
        subtract_with_borrow_regs,
        subtract_with_borrow_imm,
        and_with_immediate,
        or_with_immediate,
        and_regs,
        or_regs,
        exclusive_or_regs,
        invert_op,
        twos_complement_op,
        set_bits_masked,
        clear_bits_masked,
        add_one_op,
        subtract_one_op
    } alu_op_t;
endpackage

// *** logic/alu_sub_core.sv ***
// subtractor with borrow: a - b - cin, with borrow and half-borrow outputs
// assumes purely combinational use by the alu top
`timescale 1ns/1ps
`default_nettype none
module alu_sub_core (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    output logic [7:0] diff,
    output logic borrow,
    output logic halfBorrow,
    output logic ovf
);
    logic [8:0] wide;
    logic [4:0] low;
    always_comb begin
        wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        diff = wide[7:0];
        borrow = wide[8];
        halfBorrow = low[4];
        // signed overflow: operands differ in sign and result sign follows b
        ovf = (a[7] & ~b[7] & ~wide[7]) | (~a[7] & b[7] & wide[7]);
    end
endmodule
`default_nettype wire

// *** logic/logic_arith_alu_ops.sv ***
// single-cycle 8-bit alu for subtract, logic, complement and step operations
// assumes opStart pulses one cycle with operands held stable in that cycle
//
// Operation
// - register subtract with borrow, full flags
// - immediate subtract with borrow, full flags
// - and with immediate, Z N V only
// - or with immediate, Z N V only
// - register and/or/xor, Z N V only
// - negate: zero minus destination, full flags
// - masked set ors mask in
// - masked clear ands with inverted mask
// - increment, carry and half-carry kept
// - decrement, carry and half-carry kept
`timescale 1ns/1ps
`default_nettype none
module logic_arith_alu_ops
    import alu_ops_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic opStart,
    input wire alu_ops_pkg::alu_op_t opSel,
    input wire logic [7:0] destIn,
    input wire logic [7:0] srcIn,
    input wire logic [7:0] immIn,
    input wire logic [4:0] flagsIn,
    output logic [7:0] result,
    output logic [4:0] flagsOut,
    output logic done
);
    import alu_ops_pkg::*;

    logic [7:0] subA, subB, subD;
    logic subCin, subBorrow, subHalf, subOvf;
    logic [7:0] next_result;
    logic [4:0] next_flags;

    alu_sub_core u_sub (
        .a(subA),
        .b(subB),
        .cin(subCin),
        .diff(subD),
        .borrow(subBorrow),
        .halfBorrow(subHalf),
        .ovf(subOvf)
    );

    // one shared subtractor covers borrow, negate and decrement paths
    always_comb begin
        subA = destIn;
        subB = srcIn;
        subCin = flagsIn[FLAG_C];
        case (opSel)
            subtract_with_borrow_imm: subB = immIn;
            twos_complement_op: begin
                subA = ALL_ZERO;
                subB = destIn;
                subCin = 1'b0;
            end
            subtract_one_op: begin
                subB = ONE_VAL;
                subCin = 1'b0;
            end
            default: subB = srcIn;
        endcase
    end

    always_comb begin
        next_result = destIn;
        next_flags = flagsIn;
        case (opSel)
            subtract_with_borrow_regs, subtract_with_borrow_imm,
            twos_complement_op: begin
                next_result = subD;
                next_flags[FLAG_C] = subBorrow;
                next_flags[FLAG_H] = subHalf;
                next_flags[FLAG_V] = subOvf;
            end
            and_with_immediate: begin
                next_result = destIn & immIn;
                next_flags[FLAG_V] = 1'b0;
            end
            or_with_immediate, set_bits_masked: begin
                next_result = destIn | immIn;
                next_flags[FLAG_V] = 1'b0;
            end
            clear_bits_masked: begin
                next_result = destIn & (ALL_ONES - immIn);
                next_flags[FLAG_V] = 1'b0;
            end
            and_regs: begin
                next_result = destIn & srcIn;
                next_flags[FLAG_V] = 1'b0;
            end
            or_regs: begin
                next_result = destIn | srcIn;
                next_flags[FLAG_V] = 1'b0;
            end
            exclusive_or_regs: begin
                next_result = destIn ^ srcIn;
                next_flags[FLAG_V] = 1'b0;
            end
            invert_op: begin
                next_result = ALL_ONES - destIn;
                // complement always reports carry set, overflow cleared
                next_flags[FLAG_C] = 1'b1;
                next_flags[FLAG_V] = 1'b0;
            end
            add_one_op: begin
                next_result = destIn + ONE_VAL;
                next_flags[FLAG_V] = (destIn == (MSB_MASK - ONE_VAL));
            end
            subtract_one_op: begin
                next_result = subD;
                next_flags[FLAG_V] = (destIn == MSB_MASK);
            end
            default: next_result = destIn;
        endcase
        next_flags[FLAG_Z] = (next_result == ALL_ZERO);
        next_flags[FLAG_N] = next_result[7];
        if (opSel == OP_NONE) begin
            next_flags = flagsIn;
        end
    end

    // results land one edge after the request: single-clock completion
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            result <= ALL_ZERO;
            flagsOut <= FLAGS_RESET;
        end else if (opStart) begin
            result <= next_result;
            flagsOut <= next_flags;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done <= 1'b0;
        end else begin
            done <= opStart && (opSel != OP_NONE);
        end
    end

    property p_one_clock;
        @(posedge core_clk) disable iff (!rstn)
        (opStart && opSel != OP_NONE) |=> done;
    endproperty
    a_one_clock: assert property (p_one_clock) else $error("no done after op");

    property p_sub_borrow_regs;
        @(posedge core_clk) disable iff (!rstn)
        (opStart && opSel == subtract_with_borrow_regs) |=>
        result == 8'($past(destIn) - $past(srcIn) - {7'h00, $past(flagsIn[FLAG_C])});
    endproperty
    a_sub_borrow_regs: assert property (p_sub_borrow_regs) else $error("borrow sub wrong");

    property p_sub_borrow_imm;
        @(posedge core_clk) disable iff (!rstn)
        (opStart && opSel == subtract_with_borrow_imm) |=>
        result == 8'($past(destIn) - $past(immIn) - {7'h00, $past(flagsIn[FLAG_C])});
    endproperty
    a_sub_borrow_imm: assert property (p_sub_borrow_imm) else $error("borrow sub imm wrong");

    property p_and_imm;
        @(posedge core_clk) disable iff (!rstn)
        (opStart && opSel == and_with_immediate) |=>
        result == ($past(destIn) & $past(immIn)) && !flagsOut[FLAG_V]
        && flagsOut[FLAG_C] == $past(flagsIn[FLAG_C]);
    endproperty
    a_and_imm: assert property (p_and_imm) else $error("and imm wrong");

    property p_or_imm;
        @(posedge core_clk) disable iff (!rstn)
        (opStart && (opSel == or_with_immediate || opSel == set_bits_masked)) |=>
        result == ($past(destIn) | $past(immIn)) && !flagsOut[FLAG_V];
    endproperty
    a_or_imm: assert property (p_or_imm) else $error("or imm wrong");

    property p_xor;
        @(posedge core_clk) disable iff (!rstn)
        (opStart && opSel == exclusive_or_regs) |=>
        result == ($past(destIn) ^ $past(srcIn)) && !flagsOut[FLAG_V];
    endproperty
    a_xor: assert property (p_xor) else $error("xor wrong");

    property p_com;
        @(posedge core_clk) disable iff (!rstn)
        (opStart && opSel == invert_op) |=> result == ~$past(destIn) && flagsOut[FLAG_C];
    endproperty
    a_com: assert property (p_com) else $error("invert wrong");

    property p_negate;
        @(posedge core_clk) disable iff (!rstn)
        (opStart && opSel == twos_complement_op) |=>
        result == 8'(8'h00 - $past(destIn)) && flagsOut[FLAG_C] == ($past(destIn) != 8'h00);
    endproperty
    a_negate: assert property (p_negate) else $error("negate wrong");

    property p_mask_clear;
        @(posedge core_clk) disable iff (!rstn)
        (opStart && opSel == clear_bits_masked) |=> result == ($past(destIn) & ~$past(immIn));
    endproperty
    a_mask_clear: assert property (p_mask_clear) else $error("masked clear wrong");

    property p_inc;
        @(posedge core_clk) disable iff (!rstn)
        (opStart && opSel == add_one_op) |=> result == 8'($past(destIn) + 8'h01)
        && flagsOut[FLAG_C] == $past(flagsIn[FLAG_C])
        && flagsOut[FLAG_H] == $past(flagsIn[FLAG_H]);
    endproperty
    a_inc: assert property (p_inc) else $error("increment wrong");

    property p_decrement;
        @(posedge core_clk) disable iff (!rstn)
        (opStart && opSel == subtract_one_op) |=> result == 8'($past(destIn) - 8'h01)
        && flagsOut[FLAG_C] == $past(flagsIn[FLAG_C])
        && flagsOut[FLAG_H] == $past(flagsIn[FLAG_H]);
    endproperty
    a_decrement: assert property (p_decrement) else $error("decrement wrong");

    property p_zn;
        @(posedge core_clk) disable iff (!rstn)
        done |-> flagsOut[FLAG_Z] == (result == 8'h00) && flagsOut[FLAG_N] == result[7];
    endproperty
    a_zn: assert property (p_zn) else $error("zero or negative flag wrong");

    property p_logic_v;
        @(posedge core_clk) disable iff (!rstn)
        (opStart && (opSel == and_regs || opSel == or_regs || opSel == clear_bits_masked))
        |=> !flagsOut[FLAG_V];
    endproperty
    a_logic_v: assert property (p_logic_v) else $error("overflow not cleared");

    c_sub_borrow_zero: cover property (@(posedge core_clk) disable iff (!rstn)
        (opStart && opSel == subtract_with_borrow_regs) ##1 flagsOut[FLAG_Z]);
    c_negate_ovf: cover property (@(posedge core_clk) disable iff (!rstn)
        (opStart && opSel == twos_complement_op) ##1 flagsOut[FLAG_V]);
    c_inc_wrap: cover property (@(posedge core_clk) disable iff (!rstn)
        (opStart && opSel == add_one_op) ##1 (done && result == 8'h00));
    c_back_to_back: cover property (@(posedge core_clk) disable iff (!rstn)
        opStart ##1 opStart);
endmodule
`default_nettype wire

// *** bench/test_logic_arith_alu_ops.sv ***
// self-checking bench for the single-cycle 8-bit alu
// assumes the alu answers one cycle after each accepted request
`timescale 1ns/1ps
`default_nettype none
module test_logic_arith_alu_ops;
    import alu_ops_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic opStart = 1'b0;
    alu_op_t opSel = OP_NONE;
    logic [7:0] destIn = 8'h00;
    logic [7:0] srcIn = 8'h00;
    logic [7:0] immIn = 8'h00;
    logic [4:0] flagsIn = 5'h00;
    logic [7:0] result;
    logic [4:0] flagsOut;
    logic done;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [12:0] lastExp = 13'h0000;
    logic [7:0] corner [7] = '{8'h00, 8'h01, 8'h0f, 8'h10, 8'h7f, 8'h80, 8'hff};

    logic_arith_alu_ops u_logic_arith_alu_ops (.core_clk(core_clk), .rstn(rstn),
        .opStart(opStart), .opSel(opSel), .destIn(destIn), .srcIn(srcIn), .immIn(immIn),
        .flagsIn(flagsIn), .result(result), .flagsOut(flagsOut), .done(done));

    always #4 core_clk = ~core_clk;

    // hang guard: generous against some 600 cycles of traffic
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(string what, logic [12:0] seen, logic [12:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // reference: subtract family shares one borrow chain, carry-in only for the two borrow ops
    function automatic logic [12:0] model(alu_op_t op, logic [7:0] d, logic [7:0] s,
        logic [7:0] k, logic [4:0] f);
        logic [7:0] r;
        logic [4:0] g;
        logic [7:0] a;
        logic [7:0] b;
        logic cin;
        logic [8:0] w;
        logic [4:0] h;
        g = f;
        r = d;
        a = (op == twos_complement_op) ? 8'h00 : d;
        b = (op == twos_complement_op) ? d : ((op == subtract_with_borrow_regs) ? s : k);
        cin = (op == twos_complement_op) ? 1'b0 : f[FLAG_C];
        case (op)
            OP_NONE: return {f, d};
            subtract_with_borrow_regs, subtract_with_borrow_imm, twos_complement_op: begin
                w = {1'b0, a} - {1'b0, b} - {8'h00, cin};
                h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
                r = w[7:0];
                g[FLAG_C] = w[8];
                g[FLAG_H] = h[4];
                g[FLAG_V] = (a[7] != b[7]) && (r[7] != a[7]);
            end
            and_with_immediate: r = d & k;
            or_with_immediate, set_bits_masked: r = d | k;
            and_regs: r = d & s;
            or_regs: r = d | s;
            exclusive_or_regs: r = d ^ s;
            clear_bits_masked: r = d & (8'hff - k);
            invert_op: begin
                r = 8'hff - d;
                g[FLAG_C] = 1'b1;
            end
            add_one_op: r = d + 8'h01;
            subtract_one_op: r = d - 8'h01;
            default: r = d;
        endcase
        if (op inside {and_with_immediate, or_with_immediate, set_bits_masked, and_regs,
            or_regs, exclusive_or_regs, clear_bits_masked, invert_op}) begin
            g[FLAG_V] = 1'b0;
        end
        if (op == add_one_op) begin
            g[FLAG_V] = (d == 8'h7f);
        end
        if (op == subtract_one_op) begin
            g[FLAG_V] = (d == 8'h80);
        end
        g[FLAG_Z] = (r == 8'h00);
        g[FLAG_N] = r[7];
        return {g, r};
    endfunction

    task automatic run_op(alu_op_t op, logic [7:0] d, logic [7:0] s, logic [7:0] k,
        logic [4:0] f);
        lastExp = model(op, d, s, k, f);
        opStart = 1'b1;
        opSel = op;
        destIn = d;
        srcIn = s;
        immIn = k;
        flagsIn = f;
        @(posedge core_clk);
        #1;
        check("result", {5'h00, result}, {5'h00, lastExp[7:0]});
        check("flags", {8'h00, flagsOut}, {8'h00, lastExp[12:8]});
        check("done", {12'h000, done}, {12'h000, op != OP_NONE});
    endtask

    task automatic idle_check();
        opStart = 1'b0;
        opSel = OP_NONE;
        @(posedge core_clk);
        #1;
        check("done idle", {12'h000, done}, 13'h0000);
        check("result hold", {flagsOut, result}, lastExp);
    endtask

    task automatic reset_check();
        check("reset outputs", {flagsOut, result}, 13'h0000);
        check("reset done", {12'h000, done}, 13'h0000);
    endtask

    initial begin
        void'($urandom(32'h88af));
        repeat (2) @(posedge core_clk);
        #1;
        reset_check();
        rstn = 1'b1;
        run_op(subtract_with_borrow_regs, 8'h10, 8'h03, 8'h00, 5'h01);
        run_op(subtract_with_borrow_regs, 8'h10, 8'h0f, 8'h00, 5'h01);
        for (int p = 0; p < 2; p++) begin
            for (int o = 0; o < 14; o++) begin
                for (int j = 0; j < 7; j++) begin
                    run_op(alu_op_t'(o[3:0]), corner[j], corner[(j + 3) % 7],
                        corner[(j + 5) % 7], p ? 5'h1f : 5'h00);
                end
            end
            idle_check();
        end
        rstn = 1'b0;
        #1;
        reset_check();
        @(posedge core_clk);
        @(posedge core_clk);
        #1;
        rstn = 1'b1;
        run_op(twos_complement_op, 8'h80, 8'h00, 8'h00, 5'h00);
        for (int n = 0; n < 400; n++) begin
            run_op(alu_op_t'(4'($urandom_range(13, 0))), 8'($urandom), 8'($urandom),
                8'($urandom), 5'($urandom));
        end
        idle_check();
        tally_and_finish();
    end
endmodule
`default_nettype wire
